/* File: rtl/pmcr_pkg.sv */
package pmcr_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_POWER_CONTROL = 32'h0004_0400;
    localparam logic [31:0] ADDR_SYSTEM_STATUS = 32'h0004_0104;

    // ----------------------------------------------------------------
    // Write-mask layout
    // ----------------------------------------------------------------
    localparam int MASK_LANE_BITS = 8;
    localparam int MASK_LOW_OFFSET = 8;
    localparam int MASK_HIGH_DATA_LSB = 16;
    localparam int MASK_HIGH_OFFSET = 24;

    // ----------------------------------------------------------------
    // Power control fields
    // ----------------------------------------------------------------
    localparam int CTRL_CORE_LOWPOWER_BIT = 0;
    localparam int CTRL_REF_OUTPUT_BIT = 1;
    localparam int CTRL_CHARGE_PUMP_BIT = 2;
    localparam int CTRL_GROUND_SELECT_BIT = 3;
    localparam int CTRL_BANDGAP_BIT = 4;
    localparam int CTRL_MODE_LSB = 16;
    localparam int CTRL_LEVEL_LSB = 18;
    localparam logic [31:0] CTRL_WRITABLE = 32'h000f_001f;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Analog supply mode encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_HIGH_IMPEDANCE = 2'h0;
    localparam logic [1:0] MODE_SHORT_MAIN = 2'h1;
    localparam logic [1:0] MODE_WEAK_PULLDOWN = 2'h2;
    localparam logic [1:0] MODE_REGULATE = 2'h3;

    // ----------------------------------------------------------------
    // System status fields
    // ----------------------------------------------------------------
    localparam int STAT_UNDERVOLTAGE_BIT = 0;
    localparam int STAT_PIN_RESET_BIT = 1;
    localparam int STAT_WATCHDOG_BIT = 2;
    localparam int STAT_LOWPOWER_BIT = 3;
    localparam int STAT_IDLE_SELECT_BIT = 4;
    localparam logic [31:0] STAT_RW_BITS = 32'h0000_0010;
    localparam logic [31:0] STAT_CLEAR_BITS = 32'h0000_000f;
    localparam logic [31:0] STAT_RESET = 32'h0000_0001;

    // ----------------------------------------------------------------
    // Bus constants
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage

/* File: rtl/pmcr_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module pmcr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;

    // ----------------------------------------------------------------
    // Two flops per bit
    // ----------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                stage1_q[i] <= RESET_VALUE[i];
                sync_out[i] <= RESET_VALUE[i];
            end else begin
                stage1_q[i] <= async_in[i];
                sync_out[i] <= stage1_q[i];
            end
        end
    end

endmodule // pmcr_sync

`default_nettype wire

/* File: rtl/pmcr_regs.sv */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module pmcr_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic main_supply_low,
    input wire logic core_supply_low,
    input wire logic supply_above_1v8,
    input wire logic reset_pin_level,
    input wire logic debug_reset_event,
    input wire logic watchdog_event,
    input wire logic lowpower_entry_event,
    input wire logic idle_wake_event,
    input wire logic converter_clock_enable,
    output logic chip_reset_n,
    output logic core_reg_lowpower,
    output logic ref_output_enable,
    output logic charge_pump_enable,
    output logic charge_pump_run,
    output logic analog_ground_select,
    output logic bandgap_enable,
    output logic common_mode_reference_valid,
    output logic [1:0] analog_supply_mode,
    output logic [1:0] analog_supply_level,
    output logic supply_short_main,
    output logic supply_weak_pulldown,
    output logic supply_high_impedance,
    output logic supply_regulate,
    output logic idle_mode_select,
    output logic watchdog_event_flag,
    output logic pin_reset_flag,
    output logic undervoltage_reset_flag,
    output logic lowpower_entry_flag
);

    // ----------------------------------------------------------------
    // Masked write helper
    // ----------------------------------------------------------------
    function automatic logic [31:0] masked_write(
        input logic [31:0] old_v,
        input logic [31:0] wdata,
        input logic [31:0] writable
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < pmcr_pkg::MASK_LANE_BITS; i++) begin
            if (wdata[i + pmcr_pkg::MASK_LOW_OFFSET] && writable[i]) begin
                res[i] = wdata[i];
            end
            if (wdata[i + pmcr_pkg::MASK_HIGH_OFFSET]
                && writable[i + pmcr_pkg::MASK_HIGH_DATA_LSB]) begin
                res[i + pmcr_pkg::MASK_HIGH_DATA_LSB] =
                    wdata[i + pmcr_pkg::MASK_HIGH_DATA_LSB];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Synchronised pin and detector levels
    // ----------------------------------------------------------------
    logic [3:0] async_levels;
    logic [3:0] sync_levels;
    logic main_low_s;
    logic core_low_s;
    logic above_1v8_s;
    logic reset_pin_s;
    logic reset_pin_last_q;

    assign async_levels = {reset_pin_level, supply_above_1v8,
                           core_supply_low, main_supply_low};

    pmcr_sync #(
        .WIDTH(4),
        .RESET_VALUE(4'h0)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(async_levels),
        .sync_out(sync_levels)
    );

    assign main_low_s = sync_levels[0];
    assign core_low_s = sync_levels[1];
    assign above_1v8_s = sync_levels[2];
    assign reset_pin_s = sync_levels[3];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_pin_last_q <= 1'b0;
        end else begin
            reset_pin_last_q <= reset_pin_s;
        end
    end

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    logic undervoltage;
    logic pin_reset_rise;
    logic pin_or_debug_reset;

    assign undervoltage = main_low_s | core_low_s;
    assign pin_reset_rise = reset_pin_s & ~reset_pin_last_q;
    assign pin_or_debug_reset = pin_reset_rise | debug_reset_event;

    // ----------------------------------------------------------------
    // Bus address phase capture
    // ----------------------------------------------------------------
    logic addr_valid;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_ctrl_q;
    logic wr_stat_q;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] stat_q;
    logic [31:0] stat_d;
    logic [31:0] rdata_d;

    assign addr_valid = hsel & hready & (htrans == pmcr_pkg::HTRANS_NONSEQ);
    assign hit_ctrl = addr_valid & (haddr == pmcr_pkg::ADDR_POWER_CONTROL);
    assign hit_stat = addr_valid & (haddr == pmcr_pkg::ADDR_SYSTEM_STATUS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ctrl_q <= 1'b0;
            wr_stat_q <= 1'b0;
        end else begin
            wr_ctrl_q <= hit_ctrl & hwrite;
            wr_stat_q <= hit_stat & hwrite;
        end
    end

    // ----------------------------------------------------------------
    // Power control register next value
    // ----------------------------------------------------------------
    logic [31:0] ctrl_written;
    logic [31:0] ctrl_woken;

    assign ctrl_written = wr_ctrl_q ?
        masked_write(ctrl_q, hwdata, pmcr_pkg::CTRL_WRITABLE) : ctrl_q;

    // Wake clears low-power even against a same-cycle write
    assign ctrl_woken = idle_wake_event ?
        (ctrl_written & ~(32'h1 << pmcr_pkg::CTRL_CORE_LOWPOWER_BIT)) :
        ctrl_written;

    // Undervoltage resets the chip, control fields included
    assign ctrl_d = undervoltage ? pmcr_pkg::CTRL_RESET : ctrl_woken;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= pmcr_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ----------------------------------------------------------------
    // System status register next value
    // ----------------------------------------------------------------
    logic [31:0] stat_written;
    logic [31:0] stat_sw;
    logic wdt_d;
    logic pin_d;
    logic uv_d;
    logic lp_d;

    assign stat_written = masked_write(stat_q, hwdata,
        pmcr_pkg::STAT_RW_BITS | pmcr_pkg::STAT_CLEAR_BITS);

    // Flags only go to zero from software; the select bit follows data
    assign stat_sw = wr_stat_q ?
        ((stat_written & pmcr_pkg::STAT_RW_BITS)
         | (stat_q & stat_written & pmcr_pkg::STAT_CLEAR_BITS)) : stat_q;

    // Set beats clear on every flag
    assign wdt_d = watchdog_event
        | (stat_sw[pmcr_pkg::STAT_WATCHDOG_BIT]
           & ~undervoltage & ~pin_or_debug_reset);
    assign pin_d = pin_or_debug_reset
        | (stat_sw[pmcr_pkg::STAT_PIN_RESET_BIT] & ~undervoltage);
    assign uv_d = undervoltage
        | (stat_sw[pmcr_pkg::STAT_UNDERVOLTAGE_BIT] & ~above_1v8_s);
    assign lp_d = lowpower_entry_event
        | (stat_sw[pmcr_pkg::STAT_LOWPOWER_BIT] & ~undervoltage);

    always_comb begin
        stat_d = '0;
        stat_d[pmcr_pkg::STAT_IDLE_SELECT_BIT] =
            stat_sw[pmcr_pkg::STAT_IDLE_SELECT_BIT] & ~undervoltage;
        stat_d[pmcr_pkg::STAT_WATCHDOG_BIT] = wdt_d;
        stat_d[pmcr_pkg::STAT_PIN_RESET_BIT] = pin_d;
        stat_d[pmcr_pkg::STAT_UNDERVOLTAGE_BIT] = uv_d;
        stat_d[pmcr_pkg::STAT_LOWPOWER_BIT] = lp_d;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= pmcr_pkg::STAT_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Next values are read so a write just ahead is already visible;
    // mask lanes and reserved bits are never stored, so they read zero
    logic rd_ctrl;
    logic rd_stat;

    assign rd_ctrl = hit_ctrl & ~hwrite;
    assign rd_stat = hit_stat & ~hwrite;

    always_comb begin
        if (rd_ctrl) begin
            rdata_d = ctrl_d & pmcr_pkg::CTRL_WRITABLE;
        end else if (rd_stat) begin
            rdata_d = stat_d;
        end else begin
            rdata_d = pmcr_pkg::READ_UNMAPPED;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= pmcr_pkg::READ_UNMAPPED;
            hreadyout <= 1'b1;
            hresp <= pmcr_pkg::HRESP_OKAY;
        end else begin
            hrdata <= rdata_d;
            hreadyout <= 1'b1;
            hresp <= pmcr_pkg::HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // Analog supply mode decode
    // ----------------------------------------------------------------
    logic [1:0] mode_d;
    logic [1:0] level_d;
    logic short_d;
    logic pulldown_d;
    logic highz_d;
    logic regulate_d;

    assign mode_d = ctrl_d[pmcr_pkg::CTRL_MODE_LSB +: 2];
    assign level_d = ctrl_d[pmcr_pkg::CTRL_LEVEL_LSB +: 2];
    assign short_d = (mode_d == pmcr_pkg::MODE_SHORT_MAIN);
    assign pulldown_d = (mode_d == pmcr_pkg::MODE_WEAK_PULLDOWN);
    assign highz_d = (mode_d == pmcr_pkg::MODE_HIGH_IMPEDANCE);
    assign regulate_d = (mode_d == pmcr_pkg::MODE_REGULATE);

    // ----------------------------------------------------------------
    // Analog control outputs
    // ----------------------------------------------------------------
    logic bandgap_d;
    logic pump_en_d;

    assign bandgap_d = ctrl_d[pmcr_pkg::CTRL_BANDGAP_BIT];
    assign pump_en_d = ctrl_d[pmcr_pkg::CTRL_CHARGE_PUMP_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_reg_lowpower <= 1'b0;
            ref_output_enable <= 1'b0;
            charge_pump_enable <= 1'b0;
            charge_pump_run <= 1'b0;
            analog_ground_select <= 1'b0;
            bandgap_enable <= 1'b0;
            common_mode_reference_valid <= 1'b0;
        end else begin
            core_reg_lowpower <= ctrl_d[pmcr_pkg::CTRL_CORE_LOWPOWER_BIT];
            ref_output_enable <= ctrl_d[pmcr_pkg::CTRL_REF_OUTPUT_BIT];
            charge_pump_enable <= pump_en_d;
            charge_pump_run <= pump_en_d & converter_clock_enable;
            analog_ground_select <= ctrl_d[pmcr_pkg::CTRL_GROUND_SELECT_BIT];
            bandgap_enable <= bandgap_d;
            common_mode_reference_valid <= bandgap_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_supply_mode <= pmcr_pkg::MODE_HIGH_IMPEDANCE;
            analog_supply_level <= 2'h0;
            supply_short_main <= 1'b0;
            supply_weak_pulldown <= 1'b0;
            supply_high_impedance <= 1'b1;
            supply_regulate <= 1'b0;
        end else begin
            analog_supply_mode <= mode_d;
            analog_supply_level <= level_d;
            supply_short_main <= short_d;
            supply_weak_pulldown <= pulldown_d;
            supply_high_impedance <= highz_d;
            supply_regulate <= regulate_d;
        end
    end

    // ----------------------------------------------------------------
    // Chip reset and status outputs
    // ----------------------------------------------------------------
    // Chip stays in reset while bus reset is low, then follows detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_reset_n <= 1'b0;
        end else begin
            chip_reset_n <= ~undervoltage;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_mode_select <= 1'b0;
            watchdog_event_flag <= 1'b0;
            pin_reset_flag <= 1'b0;
            undervoltage_reset_flag <= 1'b1;
            lowpower_entry_flag <= 1'b0;
        end else begin
            idle_mode_select <= stat_d[pmcr_pkg::STAT_IDLE_SELECT_BIT];
            watchdog_event_flag <= wdt_d;
            pin_reset_flag <= pin_d;
            undervoltage_reset_flag <= uv_d;
            lowpower_entry_flag <= lp_d;
        end
    end

    // ----------------------------------------------------------------
    // Unused bus fields
    // ----------------------------------------------------------------
    // Only whole-word transfers are expected; size is not checked
    logic size_unused;

    assign size_unused = ^hsize;

endmodule // pmcr_regs

`default_nettype wire

/* File: sim/pmcr_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module pmcr_regs_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] hrdata,
    input wire logic idle_wake_event,
    input wire logic watchdog_event,
    input wire logic debug_reset_event,
    input wire logic lowpower_entry_event,
    input wire logic chip_reset_n,
    input wire logic core_reg_lowpower,
    input wire logic charge_pump_enable,
    input wire logic charge_pump_run,
    input wire logic bandgap_enable,
    input wire logic common_mode_reference_valid,
    input wire logic [1:0] analog_supply_mode,
    input wire logic supply_short_main,
    input wire logic supply_weak_pulldown,
    input wire logic supply_high_impedance,
    input wire logic supply_regulate,
    input wire logic watchdog_event_flag,
    input wire logic pin_reset_flag,
    input wire logic undervoltage_reset_flag,
    input wire logic lowpower_entry_flag
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    chk_ref_follows_bandgap: assert property (
        common_mode_reference_valid == bandgap_enable) else $error("reference valid mismatch");
    chk_pump_needs_enable: assert property (
        charge_pump_run |-> charge_pump_enable) else $error("pump runs while disabled");
    chk_mode_decode: assert property (
        {supply_regulate, supply_weak_pulldown, supply_short_main, supply_high_impedance}
        == (4'h1 << analog_supply_mode)) else $error("mode decode wrong");
    chk_wake_clears_lp: assert property (
        idle_wake_event |=> !core_reg_lowpower) else $error("wake left low power on");
    chk_watchdog_set: assert property (
        watchdog_event && !undervoltage_reset_flag |=> watchdog_event_flag)
        else $error("watchdog flag not set");
    chk_debug_set: assert property (
        debug_reset_event && !undervoltage_reset_flag |=> pin_reset_flag)
        else $error("pin flag not set");
    chk_lowpower_set: assert property (
        lowpower_entry_event && !undervoltage_reset_flag |=> lowpower_entry_flag)
        else $error("low power flag not set");
    chk_uv_hold: assert property (
        !chip_reset_n |-> undervoltage_reset_flag) else $error("chip reset without flag");
    chk_reserved_zero: assert property (
        hrdata[31:20] == 12'h0 && hrdata[15:5] == 11'h0) else $error("mask bits read nonzero");

    cover property (watchdog_event ##1 watchdog_event_flag);
    cover property (idle_wake_event && core_reg_lowpower);
    cover property (chip_reset_n ##1 !chip_reset_n);
endmodule // pmcr_regs_chk

bind pmcr_regs pmcr_regs_chk u_chk (.hclk, .hresetn, .hrdata, .idle_wake_event,
    .watchdog_event, .debug_reset_event, .lowpower_entry_event, .chip_reset_n,
    .core_reg_lowpower, .charge_pump_enable, .charge_pump_run, .bandgap_enable,
    .common_mode_reference_valid, .analog_supply_mode, .supply_short_main,
    .supply_weak_pulldown, .supply_high_impedance, .supply_regulate,
    .watchdog_event_flag, .pin_reset_flag, .undervoltage_reset_flag, .lowpower_entry_flag);

`default_nettype wire

/* File: sim/pmcr_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module pmcr_regs_tb;
    localparam logic [31:0] CTL = pmcr_pkg::ADDR_POWER_CONTROL;
    localparam logic [31:0] STA = pmcr_pkg::ADDR_SYSTEM_STATUS;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0, hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic main_supply_low = 1'h0, core_supply_low = 1'h0, supply_above_1v8 = 1'h0;
    logic reset_pin_level = 1'h0, debug_reset_event = 1'h0, watchdog_event = 1'h0;
    logic lowpower_entry_event = 1'h0, idle_wake_event = 1'h0;
    logic converter_clock_enable = 1'h0;
    logic hreadyout, hresp, chip_reset_n, core_reg_lowpower, ref_output_enable;
    logic charge_pump_enable, charge_pump_run, analog_ground_select, bandgap_enable;
    logic common_mode_reference_valid, supply_short_main, supply_weak_pulldown;
    logic supply_high_impedance, supply_regulate, idle_mode_select, watchdog_event_flag;
    logic pin_reset_flag, undervoltage_reset_flag, lowpower_entry_flag;
    logic [1:0] analog_supply_mode, analog_supply_level;
    logic [31:0] hrdata;
    wire logic hready = hreadyout;
    int fails = 0;
    int tests_run = 0;

    pmcr_regs dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .main_supply_low, .core_supply_low,
        .supply_above_1v8, .reset_pin_level, .debug_reset_event, .watchdog_event,
        .lowpower_entry_event, .idle_wake_event, .converter_clock_enable, .chip_reset_n,
        .core_reg_lowpower, .ref_output_enable, .charge_pump_enable, .charge_pump_run,
        .analog_ground_select, .bandgap_enable, .common_mode_reference_valid,
        .analog_supply_mode, .analog_supply_level, .supply_short_main,
        .supply_weak_pulldown, .supply_high_impedance, .supply_regulate,
        .idle_mode_select, .watchdog_event_flag, .pin_reset_flag,
        .undervoltage_reset_flag, .lowpower_entry_flag);

    always #5 hclk = ~hclk;

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'h1;
        htrans <= pmcr_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'h1, a, d, v);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'h0, a, 32'h0, v);
        check(v, exp);
    endtask

    // Pulse one event: 0 watchdog, 1 debug, 2 low power, 3 wake
    task automatic fire(input int k);
        {idle_wake_event, lowpower_entry_event, debug_reset_event, watchdog_event} <= 4'(1 << k);
        tick(1);
        {idle_wake_event, lowpower_entry_event, debug_reset_event, watchdog_event} <= 4'h0;
        tick(1);
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        #50000;
        fails++;
        tally_and_finish;
    end

    initial begin
        tick(5);
        hresetn <= 1'h1;
        rdc(CTL, 32'h0);
        rdc(STA, 32'h1);
        supply_above_1v8 <= 1'h1;
        tick(5);
        rdc(STA, 32'h0);
        check(32'(chip_reset_n), 32'h1);
        check(32'({hreadyout, hresp}), 32'h2);
        wr(CTL, 32'hffff_ffff);
        rdc(CTL, 32'h000f_001f);
        wr(CTL, 32'h000c_00e0);
        rdc(CTL, 32'h000f_001f);
        wr(CTL, 32'h0f00_0100);
        rdc(CTL, 32'h0000_001e);
        check(32'({bandgap_enable, analog_ground_select, charge_pump_enable,
                   ref_output_enable, core_reg_lowpower}), 32'h1e);
        check(32'(common_mode_reference_valid), 32'h1);
        check(32'(charge_pump_run), 32'h0);
        converter_clock_enable <= 1'h1;
        tick(2);
        check(32'(charge_pump_run), 32'h1);
        wr(CTL, 32'h0000_0101);
        tick(1);
        check(32'(core_reg_lowpower), 32'h1);
        fire(3);
        check(32'(core_reg_lowpower), 32'h0);
        rdc(CTL, 32'h0000_001e);
        for (int m = 0; m < 4; m++) begin
            wr(CTL, 32'h0f00_0000 | (32'(m) << 16) | (32'(3 - m) << 18));
            tick(1);
            check(32'(analog_supply_mode), 32'(m));
            check(32'(analog_supply_level), 32'(3 - m));
            check(32'({supply_regulate, supply_weak_pulldown, supply_short_main,
                       supply_high_impedance}), 32'h1 << m);
        end
        wr(32'h0004_0408, 32'hffff_ffff);
        rdc(32'h0004_0408, 32'h0);
        rdc(CTL, 32'h0003_001e);
        wr(CTL, 32'h0000_1000);
        tick(1);
        check(32'({bandgap_enable, common_mode_reference_valid}), 32'h0);
        fire(0);
        check(32'(watchdog_event_flag), 32'h1);
        fire(2);
        rdc(STA, 32'h0000_000c);
        reset_pin_level <= 1'h1;
        tick(5);
        rdc(STA, 32'h0000_000a);
        reset_pin_level <= 1'h0;
        wr(STA, 32'h0000_0201);
        rdc(STA, 32'h0000_0008);
        fire(1);
        rdc(STA, 32'h0000_000a);
        wr(STA, 32'h0000_0800);
        fire(0);
        rdc(STA, 32'h0000_0006);
        wr(STA, 32'h0000_1010);
        rdc(STA, 32'h0000_0016);
        check(32'(idle_mode_select), 32'h1);
        main_supply_low <= 1'h1;
        tick(4);
        check(32'(chip_reset_n), 32'h0);
        rdc(STA, 32'h0000_0001);
        check(32'(idle_mode_select), 32'h0);
        rdc(CTL, 32'h0);
        main_supply_low <= 1'h0;
        tick(5);
        check(32'(chip_reset_n), 32'h1);
        rdc(STA, 32'h0);
        core_supply_low <= 1'h1;
        tick(4);
        check(32'(chip_reset_n), 32'h0);
        core_supply_low <= 1'h0;
        tick(5);
        check(32'(chip_reset_n), 32'h1);
        tally_and_finish;
    end
endmodule // pmcr_regs_tb

`default_nettype wire
